// [logic/dcr_top.sv]
// Checksum unit control register, byte reorder path and output FIFO
`timescale 1ns/100ps

module dcr_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");

  a_fifo_hold: assert property (
    @(posedge clk) disable iff (!rst_n)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo head changed while held");
endmodule // dcr_fifo

module dcr_top
  import dcr_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:0]  SRC_VALID,
  input  wire logic [31:0] SRC_DATA,
  output logic      [7:0]  SRC_READY,
  output logic             OUT_VALID,
  input  wire logic        OUT_READY,
  output logic      [31:0] OUT_CALC_DATA,
  output logic      [31:0] OUT_DEST_DATA,
  output logic             OUT_ROUTED,
  output logic             OUT_REFLECT,
  output logic             OUT_IP_MODE,
  output logic      [4:0]  OUT_POLY_LEN,
  output logic      [31:0] CTRL_STATUS
);
  dcr_cfg_type  cfg_q;
  logic         wr_pend_q;
  logic         rd_pend_q;
  logic [31:0]  ctrl_word;
  logic [31:0]  wr_val;
  logic [31:0]  reordered;
  dcr_beat_type beat;
  dcr_beat_type fifo_out;
  logic         fifo_in_ready;
  logic         fifo_in_valid;
  logic         fifo_out_valid;
  logic         sel_valid;
  logic         addr_hit;

  // Unassigned positions are built as zero, so they always read zero
  always_comb begin
    ctrl_word = '0;
    ctrl_word[BYTE_ORD_POS+:2] = cfg_q.byte_order_sel;
    ctrl_word[WR_REORD_POS]    = cfg_q.write_reorder_en;
    ctrl_word[BIT_ORD_POS]     = cfg_q.bit_order_sel;
    ctrl_word[POLY_LEN_POS+:5] = cfg_q.poly_length;
    ctrl_word[EN_POS]          = cfg_q.checker_enable;
    ctrl_word[APP_POS]         = cfg_q.result_append;
    ctrl_word[TYP_POS]         = cfg_q.checker_type;
    ctrl_word[CH_POS+:3]       = cfg_q.channel_select;
  end

  assign wr_val   = HWDATA & CTRL_WMASK;
  assign addr_hit = (HADDR[31:2] == CTRL_ADDR[31:2]);

  // Zero-wait slave, always OKAY
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (HREADY) begin
      wr_pend_q <= HSEL && HTRANS[1] && HWRITE && addr_hit;
      rd_pend_q <= HSEL && HTRANS[1] && !HWRITE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cfg_q.byte_order_sel   <= CTRL_RESET[BYTE_ORD_POS+:2];
      cfg_q.write_reorder_en <= CTRL_RESET[WR_REORD_POS];
      cfg_q.bit_order_sel    <= CTRL_RESET[BIT_ORD_POS];
      cfg_q.poly_length      <= CTRL_RESET[POLY_LEN_POS+:5];
      cfg_q.checker_enable   <= CTRL_RESET[EN_POS];
      cfg_q.result_append    <= CTRL_RESET[APP_POS];
      cfg_q.checker_type     <= CTRL_RESET[TYP_POS];
      cfg_q.channel_select   <= CTRL_RESET[CH_POS+:3];
    end else if (wr_pend_q) begin
      cfg_q.byte_order_sel   <= wr_val[BYTE_ORD_POS+:2];
      cfg_q.write_reorder_en <= wr_val[WR_REORD_POS];
      cfg_q.bit_order_sel    <= wr_val[BIT_ORD_POS];
      cfg_q.poly_length      <= wr_val[POLY_LEN_POS+:5];
      cfg_q.checker_enable   <= wr_val[EN_POS];
      // Append is blocked while destination reordering is on
      cfg_q.result_append    <= wr_val[APP_POS]
                                && !wr_val[WR_REORD_POS];
      cfg_q.checker_type     <= wr_val[TYP_POS];
      cfg_q.channel_select   <= wr_val[CH_POS+:3];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      HRDATA <= '0;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= addr_hit ? ctrl_word : '0;
    end
  end

  // Constant answers still come from flops, as HRDATA and the mode outputs do
  always_ff @(posedge CLK) begin
    HREADYOUT <= 1'b1;
    HRESP     <= 1'b0;
  end

  always_comb begin
    case (cfg_q.byte_order_sel)
      ORD_NONE:      reordered = SRC_DATA;
      ORD_WORD_REV:  reordered = {SRC_DATA[7:0], SRC_DATA[15:8],
                                  SRC_DATA[23:16], SRC_DATA[31:24]};
      ORD_HALF_SWAP: reordered = {SRC_DATA[15:0], SRC_DATA[31:16]};
      default:       reordered = {SRC_DATA[23:16], SRC_DATA[31:24],
                                  SRC_DATA[7:0], SRC_DATA[15:8]};
    endcase
  end

  // Only the selected channel is fed; other channels bypass untouched
  assign sel_valid     = SRC_VALID[cfg_q.channel_select];
  assign fifo_in_valid = cfg_q.checker_enable && sel_valid;
  assign beat.calc_data = reordered;
  assign beat.dest_data = cfg_q.write_reorder_en ? reordered
                                                 : SRC_DATA;

  always_comb begin
    SRC_READY = 8'hFF;
    if (cfg_q.checker_enable) begin
      SRC_READY[cfg_q.channel_select] = fifo_in_ready;
    end
  end

  dcr_fifo #(
    .WIDTH (2*DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RESETN),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (beat),
    .out_valid (fifo_out_valid),
    .out_ready (OUT_READY),
    .out_data  (fifo_out)
  );

  assign OUT_VALID     = fifo_out_valid;
  assign OUT_CALC_DATA = fifo_out.calc_data;
  assign OUT_DEST_DATA = fifo_out.dest_data;

  // Mode outputs to the checksum engine, plus the registered copy of the control word on CTRL_STATUS
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OUT_ROUTED   <= 1'b0;
      OUT_REFLECT  <= 1'b0;
      OUT_IP_MODE  <= 1'b0;
      OUT_POLY_LEN <= '0;
      CTRL_STATUS  <= '0;
    end else begin
      OUT_ROUTED   <= cfg_q.checker_enable;
      OUT_REFLECT  <= cfg_q.bit_order_sel;
      OUT_IP_MODE  <= cfg_q.checker_type;
      // Field is length minus one; zeroed in IP mode where it has no use
      OUT_POLY_LEN <= cfg_q.checker_type ? 5'h00
                                         : cfg_q.poly_length;
      CTRL_STATUS  <= ctrl_word;
    end
  end

  // Stream steps: a word enters an empty FIFO, then heads the output
  sequence s_word_into_empty;
    fifo_in_valid && fifo_in_ready && !fifo_out_valid;
  endsequence

  sequence s_word_at_head;
    OUT_VALID && OUT_CALC_DATA == $past(beat.calc_data)
      && OUT_DEST_DATA == $past(beat.dest_data);
  endsequence

  // Bus steps: write address phase, then its data phase
  sequence s_ctrl_write;
    (HREADY && HSEL && HTRANS[1] && HWRITE && addr_hit) ##1 HREADY;
  endsequence

  a_append_block: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.write_reorder_en |-> !cfg_q.result_append)
    else $error("append set with reorder");

  a_reserved_zero: assert property (
    @(posedge CLK) disable iff (!RESETN)
    (ctrl_word & ~CTRL_WMASK) == 32'h0)
    else $error("reserved bit nonzero");

  a_ip_len_zero: assert property (
    @(posedge CLK) disable iff (!RESETN)
    $past(cfg_q.checker_type) |-> OUT_POLY_LEN == 5'h00)
    else $error("poly length in ip mode");

  a_lfsr_len: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !$past(cfg_q.checker_type)
      |-> OUT_POLY_LEN == $past(cfg_q.poly_length))
    else $error("poly length wrong");

  a_no_swap: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.byte_order_sel == ORD_NONE |-> reordered == SRC_DATA)
    else $error("data swapped in mode 0");

  a_word_rev: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.byte_order_sel == ORD_WORD_REV |-> reordered == {SRC_DATA[7:0],
      SRC_DATA[15:8], SRC_DATA[23:16], SRC_DATA[31:24]})
    else $error("word reverse wrong");

  a_half_swap: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.byte_order_sel == ORD_HALF_SWAP |-> reordered[15:0] ==
      SRC_DATA[31:16] && reordered[31:16] == SRC_DATA[15:0])
    else $error("half swap wrong");

  a_byte_half: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.byte_order_sel == ORD_BYTE_HALF |-> reordered[15:0] ==
      {SRC_DATA[7:0], SRC_DATA[15:8]} && reordered[31:16] ==
      {SRC_DATA[23:16], SRC_DATA[31:24]})
    else $error("byte swap in half wrong");

  a_dest_raw: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !cfg_q.write_reorder_en |-> beat.dest_data == SRC_DATA)
    else $error("dest data altered");

  a_dest_reorder: assert property (
    @(posedge CLK) disable iff (!RESETN)
    cfg_q.write_reorder_en |-> beat.dest_data == reordered)
    else $error("dest data not reordered");

  a_bypass_ready: assert property (
    @(posedge CLK) disable iff (!RESETN)
    !cfg_q.checker_enable |-> SRC_READY == 8'hFF && !fifo_in_valid)
    else $error("bypass stalled");

  a_word_latency: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_word_into_empty |=> s_word_at_head)
    else $error("taken word not shown");

  a_routed_follow: assert property (
    @(posedge CLK) disable iff (!RESETN)
    1'b1 |=> OUT_ROUTED == $past(cfg_q.checker_enable))
    else $error("routed output stale");

  a_mode_follow: assert property (
    @(posedge CLK) disable iff (!RESETN)
    1'b1 |=> OUT_IP_MODE == $past(cfg_q.checker_type)
      && OUT_REFLECT == $past(cfg_q.bit_order_sel))
    else $error("mode outputs stale");

  a_chan_feed: assert property (
    @(posedge CLK) disable iff (!RESETN)
    fifo_in_valid |-> SRC_VALID[cfg_q.channel_select])
    else $error("wrong channel fed");

  a_write_lands: assert property (
    @(posedge CLK) disable iff (!RESETN)
    s_ctrl_write |=> ctrl_word[CH_POS+:3] == $past(HWDATA[CH_POS+:3])
      && ctrl_word[POLY_LEN_POS+:5] == $past(HWDATA[POLY_LEN_POS+:5]))
    else $error("control write lost");

  a_read_word: assert property (
    @(posedge CLK) disable iff (!RESETN)
    rd_pend_q |-> HRDATA == $past(addr_hit ? ctrl_word : 32'h0))
    else $error("read data wrong");

  a_status_copy: assert property (
    @(posedge CLK) disable iff (!RESETN)
    1'b1 |=> CTRL_STATUS == $past(ctrl_word))
    else $error("status copy stale");
endmodule // dcr_top

// [logic/dcr_pkg.sv]
// Package for the checksum reorder control block
package dcr_pkg;
  localparam logic [31:0] CTRL_ADDR     = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK    = 32'h3900_1FE7;
  localparam int          BYTE_ORD_POS  = 28;
  localparam int          WR_REORD_POS  = 27;
  localparam int          BIT_ORD_POS   = 24;
  localparam int          POLY_LEN_POS  = 8;
  localparam int          EN_POS        = 7;
  localparam int          APP_POS       = 6;
  localparam int          TYP_POS       = 5;
  localparam int          CH_POS        = 0;
  localparam int          FIFO_DEPTH    = 4;
  localparam int          DATA_W        = 32;
  localparam logic [1:0]  ORD_NONE      = 2'h0;
  localparam logic [1:0]  ORD_WORD_REV  = 2'h1;
  localparam logic [1:0]  ORD_HALF_SWAP = 2'h2;
  localparam logic [1:0]  ORD_BYTE_HALF = 2'h3;

  typedef struct packed {
    logic [1:0] byte_order_sel;
    logic       write_reorder_en;
    logic       bit_order_sel;
    logic [4:0] poly_length;
    logic       checker_enable;
    logic       result_append;
    logic       checker_type;
    logic [2:0] channel_select;
  } dcr_cfg_type;

  typedef struct packed {
    logic [31:0] calc_data;
    logic [31:0] dest_data;
  } dcr_beat_type;
endpackage

// [testbench/dcr_dma_model.sv]
// DMA channel source and destination drain model
`timescale 1ns/100ps
module dcr_dma_model (
  input  wire logic        clk,
  input  wire logic        stall,
  input  wire logic [7:0]  rdy,
  output logic      [7:0]  vld,
  output logic      [31:0] dat,
  output logic             out_rdy
);
  initial begin
    vld = 8'h00;
    dat = 32'h0;
    out_rdy = 1'b0;
  end
  // Drain side may stall; readiness follows one edge late
  always @(posedge clk) out_rdy <= !stall;
  // Whole aligned words only, each held until taken
  task automatic send(input logic [2:0] ch, input int n,
                      input logic [31:0] b);
    for (int i = 0; i < n; i++) begin
      vld <= 8'h01 << ch;
      dat <= b + 32'(i);
      do @(posedge clk); while (rdy[ch] !== 1'b1);
    end
    vld <= 8'h00;
    // Released line must not keep showing the last word
    dat <= ~(b + 32'(n));
  endtask
endmodule // dcr_dma_model

// [testbench/testbench.sv]
// Self-checking bench for the checksum reorder control block
`timescale 1ns/100ps
module testbench;
  import dcr_pkg::*;
  logic        CLK = 1'b0, RESETN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, CTRL_STATUS, rd;
  logic [31:0] OUT_CALC_DATA, OUT_DEST_DATA, SRC_DATA;
  logic [1:0]  HTRANS = 2'h0;
  logic [2:0]  HSIZE = 3'h2;
  logic [7:0]  SRC_VALID, SRC_READY;
  logic [4:0]  OUT_POLY_LEN;
  logic        HREADYOUT, HRESP, OUT_VALID, OUT_READY, OUT_ROUTED;
  logic        OUT_REFLECT, OUT_IP_MODE, stall = 1'b1;
  int          fails = 0, cmp_count = 0, cyc = 0;

  always #20 CLK = ~CLK;
  dcr_top dut_u (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADYOUT),
    .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .SRC_VALID(SRC_VALID), .SRC_DATA(SRC_DATA),
    .SRC_READY(SRC_READY), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_CALC_DATA(OUT_CALC_DATA), .OUT_DEST_DATA(OUT_DEST_DATA),
    .OUT_ROUTED(OUT_ROUTED), .OUT_REFLECT(OUT_REFLECT),
    .OUT_IP_MODE(OUT_IP_MODE), .OUT_POLY_LEN(OUT_POLY_LEN),
    .CTRL_STATUS(CTRL_STATUS));
  dcr_dma_model dma_u (.clk(CLK), .stall(stall), .rdy(SRC_READY),
    .vld(SRC_VALID), .dat(SRC_DATA), .out_rdy(OUT_READY));

  task automatic chk(input string nm, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run is under two hundred cycles; the ceiling leaves wide margin
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end

  task automatic ahb(input logic w, input logic [31:0] a, d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic cfgw(input logic [31:0] v);
    ahb(1'b1, CTRL_ADDR, v);
    repeat (2) @(posedge CLK);
  endtask
  function automatic logic [31:0] cv(logic [1:0] bo, logic wb, bi,
      logic [4:0] pl, logic en, ty, logic [2:0] ch);
    return {2'h0, bo, wb, 2'h0, bi, 11'h0, pl, en, 1'b0, ty, 2'h0, ch};
  endfunction
  function automatic logic [31:0] ro(logic [1:0] s, logic [31:0] w);
    case (s)
      2'h0: return w;
      2'h1: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      2'h2: return {w[15:0], w[31:16]};
      default: return {w[23:16], w[31:24], w[7:0], w[15:8]};
    endcase
  endfunction
  task automatic pop(input logic [31:0] ec, ed);
    do @(negedge CLK); while (!(OUT_VALID === 1'b1 && OUT_READY === 1'b1));
    chk("calc", ec, OUT_CALC_DATA);
    chk("dest", ed, OUT_DEST_DATA);
    @(posedge CLK);
  endtask

  task automatic t_regs();
    ahb(1'b0, CTRL_ADDR, 32'h0);
    chk("reset", 32'h0, rd);
    ahb(1'b1, CTRL_ADDR, 32'hFFFFFFFF);
    ahb(1'b0, CTRL_ADDR, 32'h0);
    chk("ones", 32'h39001FA7, rd);
    ahb(1'b1, CTRL_ADDR, 32'h40);
    ahb(1'b0, CTRL_ADDR, 32'h0);
    chk("append", 32'h40, rd);
    chk("status", 32'h40, CTRL_STATUS);
    ahb(1'b0, 32'h4, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, 32'h4, 32'hFFFFFFFF);
    ahb(1'b0, CTRL_ADDR, 32'h0);
    chk("shadow", 32'h40, rd);
    chk("okay", 32'h1, {HRESP, HREADYOUT});
    $display("test regs done");
  endtask
  task automatic t_order();
    logic [31:0] d;
    d = 32'hA1B2C3D4;
    for (int s = 0; s < 4; s++) for (int w = 0; w < 2; w++) begin
      cfgw(cv(2'(s), w[0], 1'b0, 5'h0, 1'b1, 1'b0, 3'(s + 4 * w)));
      dma_u.send(3'(s + 4 * w), 1, d);
      pop(ro(2'(s), d), w ? ro(2'(s), d) : d);
      chk("routed", 32'h1, OUT_ROUTED);
    end
    $display("test order done");
  endtask
  task automatic t_mode();
    for (int t = 0; t < 2; t++) for (int b = 0; b < 2; b++) begin
      cfgw(cv(2'h0, 1'b0, b[0], 5'h11, 1'b1, t[0], 3'h0));
      chk("ip", 32'(t), OUT_IP_MODE);
      chk("reflect", 32'(b), OUT_REFLECT);
      chk("poly_length", t ? 32'h0 : 32'h11, OUT_POLY_LEN);
    end
    $display("test mode done");
  endtask
  task automatic t_fifo();
    stall <= 1'b1;
    cfgw(cv(2'h0, 1'b0, 1'b0, 5'h0, 1'b1, 1'b0, 3'h5));
    dma_u.send(3'h5, FIFO_DEPTH, 32'h10);
    @(negedge CLK);
    chk("full", 32'hDF, SRC_READY);
    @(posedge CLK);
    stall <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
      pop(32'h10 + 32'(i), 32'h10 + 32'(i));
    cfgw(32'h0);
    chk("bypass", 32'hFF, SRC_READY);
    chk("unrouted", 32'h0, OUT_ROUTED);
    $display("test fifo done");
  endtask
  task automatic t_reset();
    stall <= 1'b1;
    cfgw(cv(2'h1, 1'b1, 1'b1, 5'h1F, 1'b1, 1'b1, 3'h2));
    dma_u.send(3'h2, 2, 32'h55);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    stall <= 1'b0;
    @(posedge CLK);
    chk("rst_valid", 32'h0, 32'(OUT_VALID));
    chk("rst_status", 32'h0, CTRL_STATUS);
    chk("rst_mode", 32'h0, {OUT_ROUTED, OUT_REFLECT, OUT_IP_MODE,
        OUT_POLY_LEN});
    chk("rst_ready", 32'hFF, SRC_READY);
    ahb(1'b0, CTRL_ADDR, 32'h0);
    chk("rst_reg", 32'h0, rd);
    $display("test reset done");
  endtask

  initial begin
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    stall <= 1'b0;
    @(posedge CLK);
    t_regs();
    t_order();
    t_mode();
    t_fifo();
    t_reset();
    summarize();
  end
endmodule // testbench
